// ---- sld_defs.svh ----
// Constants for the eight-channel sink driver with a two-wire target port.
// Assumes it is included by both design files by its bare name.
`ifndef SLD_DEFS_SVH
`define SLD_DEFS_SVH

`define SLD_GROUP_ID      4'h6
`define SLD_SUB_WRITE     8'h11
`define SLD_SUB_READ      8'h22
`define SLD_SUB_XFER      8'h44
`define SLD_OUT_OFF       8'h00
`define SLD_SHIFT_RESET   8'h00

`endif

// ---- sld_pkg.sv ----
// Types shared by the sink driver design files.
// Assumes nothing of its surroundings.
package sld_pkg;

  // Bus target sequencer states
  typedef enum logic [3:0] {
    SLD_IDLE,
    SLD_ADDR,
    SLD_ADDR_ACK,
    SLD_SUB,
    SLD_SUB_ACK,
    SLD_WDATA,
    SLD_WDATA_ACK,
    SLD_RDATA,
    SLD_RDATA_ACK,
    SLD_IGNORE
  } sld_state_e;

endpackage

// ---- sld_out_stage.sv ----
// Output stage: gates the storage register onto the eight sink channels.
// Assumes oe_n and over_temp are synchronous to clk.
`include "sld_defs.svh"

module sld_out_stage #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] store_data,
  input  wire logic             oe_n,
  input  wire logic             over_temp,
  output logic      [WIDTH-1:0] sink_on
);

  // ************************************************************
  // Transparent gating, no latch between store and buffer
  // ************************************************************
  // A one turns the sink on; enable high or overheating forces all off
  always_comb begin
    if (oe_n || over_temp) begin // RULE5 RULE9
      sink_on = '0;
    end else begin
      sink_on = store_data; // RULE6 RULE7
    end
  end

endmodule

// ---- sld_sink_driver.sv ----
// Eight-channel low-side sink driver behind a two-wire bus target.
// Assumes scl and sda_in are synchronous to clk and already filtered.
//
// Behaviour
// RULE1: An 8-bit shift register feeds an 8-bit storage register driving the outputs.
// RULE2: Data is shifted in only after group identifier and device address both match.
// RULE3: The controller sends a subaddress that selects write, read-back or transfer.
// RULE4: Three subaddress codes each make one strobe for write, read and transfer.
// RULE5: Output enable high turns all eight sinks off.
// RULE6: Output enable low passes the storage register straight to the buffers.
// RULE7: A zero bit leaves its sink off and a one bit turns it on.
// RULE8: Power-up clear sets every internal register to the all-off value.
// RULE9: An overtemperature report forces all sinks off.
// RULE10: Data is only pulled low open-drain, for acknowledge and read data.
// RULE11: Power-up clear returns the bus sequencer to idle and all outputs off.
// RULE12: The three address-select pins must match the low address bits.
`include "sld_defs.svh"

module sld_sink_driver #(
  parameter int WIDTH = 8
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic addr_select_bit0,
  input  wire logic addr_select_bit1,
  input  wire logic addr_select_bit2,
  input  wire logic oe_n,
  input  wire logic over_temp,
  output logic      sink_out_0,
  output logic      sink_out_1,
  output logic      sink_out_2,
  output logic      sink_out_3,
  output logic      sink_out_4,
  output logic      sink_out_5,
  output logic      sink_out_6,
  output logic      sink_out_7
);

  // ************************************************************
  // Bus line edge and condition detection
  // ************************************************************
  logic                   scl_d;
  logic                   sda_d;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_cond;
  logic                   stop_cond;
  sld_pkg::sld_state_e    state;
  logic [7:0]             rx_byte;
  logic [3:0]             bit_cnt;
  logic [7:0]             sub_code;
  logic [WIDTH-1:0]       shift_reg;
  logic [WIDTH-1:0]       store_reg;
  logic [WIDTH-1:0]       sink_on;
  logic [7:0]             tx_byte;
  logic                   addr_match;
  logic                   wr_strobe;
  logic                   rd_strobe;
  logic                   xfer_strobe;
  logic                   byte_done;
  logic [7:0]             next_rx_byte;
  logic                   ack_low;
  logic                   ack_state;
  logic                   ack_phase;
  logic                   rd_again;

  // Previous line levels for edge detection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda_in;
    end
  end

  assign scl_rise   = scl & ~scl_d;
  assign scl_fall   = ~scl & scl_d;
  assign start_cond = scl & scl_d & sda_d & ~sda_in;
  assign stop_cond  = scl & scl_d & ~sda_d & sda_in;

  // ************************************************************
  // Receive shifter and bit counter
  // ************************************************************
  assign next_rx_byte = {rx_byte[6:0], sda_in};
  assign byte_done    = scl_rise && (bit_cnt == 4'h7);

  // Upper nibble group id, next three bits the pin address, low bit read flag
  assign addr_match = (next_rx_byte[7:4] == `SLD_GROUP_ID) && // RULE2
                      (next_rx_byte[3:1] == {addr_select_bit2, addr_select_bit1,
                                             addr_select_bit0}); // RULE12

  // Bits sampled on rising clock; counter cleared at each start and wrapped to zero on the eighth bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_byte <= 8'h00;
      bit_cnt <= 4'h0;
    end else if (start_cond) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise) begin
      if (state == sld_pkg::SLD_ADDR || state == sld_pkg::SLD_SUB ||
          state == sld_pkg::SLD_WDATA || state == sld_pkg::SLD_RDATA) begin
        rx_byte <= next_rx_byte;
        bit_cnt <= (bit_cnt == 4'h7) ? 4'h0 : bit_cnt + 4'h1;
      end
    end
  end

  // ************************************************************
  // Bus target sequencer
  // ************************************************************
  // Ninth-bit slot of every byte, whoever drives it
  assign ack_state = (state == sld_pkg::SLD_ADDR_ACK) ||
                     (state == sld_pkg::SLD_SUB_ACK) ||
                     (state == sld_pkg::SLD_WDATA_ACK) ||
                     (state == sld_pkg::SLD_RDATA_ACK);

  // An acknowledge slot spans two falling clocks: the first opens it, the
  // second closes it, so the ninth pulse is never taken as a data bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_phase <= 1'b0;
    end else if (start_cond || stop_cond || byte_done) begin
      ack_phase <= 1'b0;
    end else if (scl_fall && ack_state) begin
      ack_phase <= ~ack_phase;
    end
  end

  // Read flag is ignored: direction comes from the subaddress in this block
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= sld_pkg::SLD_IDLE; // RULE11
    end else if (start_cond) begin
      state <= sld_pkg::SLD_ADDR;
    end else if (stop_cond) begin
      state <= sld_pkg::SLD_IDLE;
    end else if (scl_fall && ack_state && ack_phase) begin
      case (state)
        sld_pkg::SLD_ADDR_ACK: begin
          state <= sld_pkg::SLD_SUB;
        end
        sld_pkg::SLD_SUB_ACK: begin
          if (sub_code == `SLD_SUB_READ) begin
            state <= sld_pkg::SLD_RDATA;
          end else if (sub_code == `SLD_SUB_WRITE) begin
            state <= sld_pkg::SLD_WDATA;
          end else begin
            state <= sld_pkg::SLD_IGNORE;
          end
        end
        sld_pkg::SLD_WDATA_ACK: begin
          state <= sld_pkg::SLD_WDATA;
        end
        sld_pkg::SLD_RDATA_ACK: begin
          // A released slot from the controller ends the read-back
          state <= ack_low ? sld_pkg::SLD_RDATA : sld_pkg::SLD_IGNORE;
        end
        default: begin
          state <= state;
        end
      endcase
    end else if (byte_done) begin
      case (state)
        sld_pkg::SLD_ADDR: begin
          state <= addr_match ? sld_pkg::SLD_ADDR_ACK : sld_pkg::SLD_IGNORE; // RULE2
        end
        sld_pkg::SLD_SUB: begin
          state <= sld_pkg::SLD_SUB_ACK;
        end
        sld_pkg::SLD_WDATA: begin
          state <= sld_pkg::SLD_WDATA_ACK;
        end
        sld_pkg::SLD_RDATA: begin
          state <= sld_pkg::SLD_RDATA_ACK;
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end

  // Target releases the line during read ack; a high there ends the read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_low <= 1'b0;
    end else if (scl_rise && state == sld_pkg::SLD_RDATA_ACK) begin
      ack_low <= ~sda_in;
    end
  end

  // ************************************************************
  // Subaddress decode and control strobes
  // ************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sub_code <= 8'h00; // RULE8
    end else if (byte_done && state == sld_pkg::SLD_SUB) begin
      sub_code <= next_rx_byte; // RULE3
    end
  end

  // One strobe per code; transfer fires once its subaddress is taken
  assign wr_strobe   = byte_done && state == sld_pkg::SLD_WDATA; // RULE4
  assign rd_strobe   = scl_fall && ack_phase && state == sld_pkg::SLD_SUB_ACK &&
                       sub_code == `SLD_SUB_READ; // RULE4
  assign rd_again    = scl_fall && ack_phase && state == sld_pkg::SLD_RDATA_ACK && ack_low;
  assign xfer_strobe = byte_done && state == sld_pkg::SLD_SUB &&
                       next_rx_byte == `SLD_SUB_XFER; // RULE4

  // ************************************************************
  // Shift and storage registers
  // ************************************************************
  // Data is taken only in the write phase, reached after an address match;
  // a byte commits on its eighth bit so the rising clock of a stop adds no stray bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_reg <= `SLD_SHIFT_RESET; // RULE8
    end else if (wr_strobe) begin
      shift_reg <= WIDTH'(next_rx_byte); // RULE1 RULE2
    end
  end

  // Storage updates only on the transfer strobe, so writes do not flicker
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      store_reg <= `SLD_OUT_OFF; // RULE8 RULE11
    end else if (xfer_strobe) begin
      store_reg <= shift_reg; // RULE1
    end
  end

  // Read-back returns the shift register as last written
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_byte <= 8'h00;
    end else if (rd_strobe || rd_again) begin
      tx_byte <= 8'(shift_reg);
    end else if (scl_fall && state == sld_pkg::SLD_RDATA) begin
      tx_byte <= {tx_byte[6:0], 1'b1};
    end
  end

  // ************************************************************
  // Open-drain data line
  // ************************************************************
  // Only ever pulls low, and only while scl is low, so no false start or stop
  // is made; the first read bit goes out on the fall that closes the ack slot
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sda_oe <= 1'b0;
    end else if (start_cond || stop_cond) begin
      sda_oe <= 1'b0;
    end else if (rd_strobe || rd_again) begin
      sda_oe <= ~shift_reg[WIDTH-1]; // RULE10
    end else if (scl_fall && state == sld_pkg::SLD_RDATA) begin
      sda_oe <= ~tx_byte[6]; // RULE10
    end else if (scl_fall && ack_state) begin
      // Pull on opening our own ack slot; release for the controller's
      sda_oe <= ~ack_phase && (state != sld_pkg::SLD_RDATA_ACK); // RULE10
    end
  end

  assign sda_out = 1'b0; // RULE10

  // ************************************************************
  // Output stage
  // ************************************************************
  sld_out_stage #(
    .WIDTH (WIDTH)
  ) sld_out_stage_i (
    .store_data (store_reg),
    .oe_n       (oe_n),
    .over_temp  (over_temp),
    .sink_on    (sink_on)
  );

  assign {sink_out_7, sink_out_6, sink_out_5, sink_out_4,
          sink_out_3, sink_out_2, sink_out_1, sink_out_0} = 8'(sink_on);

  // ************************************************************
  // Checks
  // ************************************************************
  AST_OE_OFF: assert property (@(posedge clk) disable iff (reset)
    oe_n |-> (sink_on == '0)) else $error("sinks on while enable high"); // RULE5
  AST_PASS: assert property (@(posedge clk) disable iff (reset)
    (!oe_n && !over_temp) |-> (sink_on == store_reg)) else $error("store not passed"); // RULE6
  AST_HOT: assert property (@(posedge clk) disable iff (reset)
    over_temp |-> (sink_out_0 == 1'b0 && sink_on == '0)) else $error("sinks on while hot"); // RULE9
  AST_XFER: assert property (@(posedge clk) disable iff (reset)
    xfer_strobe |=> (store_reg == $past(shift_reg))) else $error("transfer lost"); // RULE1
  AST_HOLD: assert property (@(posedge clk) disable iff (reset)
    !xfer_strobe |=> $stable(store_reg)) else $error("store changed without transfer"); // RULE4
  AST_SHIFT_GATE: assert property (@(posedge clk) disable iff (reset)
    (state != sld_pkg::SLD_WDATA) |=> $stable(shift_reg)) else $error("shift outside write"); // RULE2
  AST_NOMATCH: assert property (@(posedge clk) disable iff (reset)
    (byte_done && state == sld_pkg::SLD_ADDR && !addr_match) |=>
      (state == sld_pkg::SLD_IGNORE)) else $error("foreign address answered"); // RULE12
  AST_SUB: assert property (@(posedge clk) disable iff (reset)
    (byte_done && state == sld_pkg::SLD_SUB) |=> (sub_code == $past(next_rx_byte)))
    else $error("subaddress not taken"); // RULE3
  AST_OD_SLOT: assert property (@(posedge clk) disable iff (reset)
    sda_oe |-> (ack_state || state == sld_pkg::SLD_RDATA))
    else $error("data line pulled outside a slot"); // RULE10
  AST_DRIVE_LOW: assert property (@(posedge clk) disable iff (reset)
    sda_out == 1'b0) else $error("data line driven high"); // RULE10
  AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (reset)
    (state == sld_pkg::SLD_IGNORE) ##1 (state == sld_pkg::SLD_IGNORE) |-> !sda_oe)
    else $error("line pulled while ignoring"); // RULE11

endmodule

// ---- sld_ctrl_model.sv ----
// Behavioural two-wire bus controller that faces the sink driver.
// Assumes a pull-up on the data wire; the bench resolves the wire level.
module sld_ctrl_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 1ns;

  // ****************
  // Bus cycles
  // ****************
  // Half bit of ten clocks keeps scl near 2 MHz, slow enough to sample
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Data falls while scl high
  task automatic start();
    sda_pull <= 1'b0;
    scl <= 1'b1;
    hold(10);
    sda_pull <= 1'b1;
    hold(10);
    scl <= 1'b0;
    hold(5);
  endtask

  // Data rises while scl high, then the bus is free
  task automatic stop();
    sda_pull <= 1'b1;
    hold(5);
    scl <= 1'b1;
    hold(10);
    sda_pull <= 1'b0;
    hold(10);
  endtask

  // One clock pulse; the wire is sampled mid high phase
  task automatic bit_slot(output logic v);
    hold(5);
    scl <= 1'b1;
    hold(5);
    v = sda;
    hold(5);
    scl <= 1'b0;
    hold(5);
  endtask

  // Byte out MSB first; ack is the target pulling data low
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      sda_pull <= ~d[i];
      bit_slot(v);
    end
    sda_pull <= 1'b0;
    bit_slot(v);
    ack = ~v;
  endtask

  // Address, subaddress and an optional data byte in one frame
  task automatic xfer(input logic [7:0] adr, input logic [7:0] sub,
                      input logic [7:0] dat, input bit nd, output logic ack);
    logic a;
    start();
    wr_byte(adr, ack);
    if (ack) begin
      wr_byte(sub, a);
      if (nd) begin
        wr_byte(dat, a);
      end
    end
    stop();
  endtask

  // Read-back frame; a released ack slot ends the return
  task automatic rd(input logic [7:0] adr, output logic [7:0] d);
    logic a;
    start();
    wr_byte(adr, a);
    wr_byte(8'h22, a);
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i]);
    end
    bit_slot(a);
    stop();
  endtask
endmodule

// ---- i2c_led_sink_driver_tb_top.sv ----
// Self-checking bench for the eight-channel sink driver.
// Assumes sld_defs.svh and the controller model are compiled with it.
`include "sld_defs.svh"

module i2c_led_sink_driver_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************
  // Harness
  // ****************
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       oe_n = 1'b1;
  logic       over_temp = 1'b0;
  logic       pin0 = 1'b0;
  logic       pin1 = 1'b0;
  logic       pin2 = 1'b0;
  wire  [2:0] pins = {pin2, pin1, pin0};
  logic       scl;
  logic       sda_pull;
  logic       sda_out;
  logic       sda_oe;
  wire        sink0, sink1, sink2, sink3, sink4, sink5, sink6, sink7;
  wire  [7:0] sinks = {sink7, sink6, sink5, sink4, sink3, sink2, sink1, sink0};
  wire        sda = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
  int         error_cnt = 0;
  int         n_checks = 0;

  // About 38 MHz clock: the 12.5 ns half period rounds to 13 ns at 1 ns precision
  always #12.5 clk = ~clk;

  sld_sink_driver sld_sink_driver_i (
    .clk(clk), .reset(reset), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_select_bit0(pin0), .addr_select_bit1(pin1),
    .addr_select_bit2(pin2), .oe_n(oe_n), .over_temp(over_temp),
    .sink_out_0(sink0), .sink_out_1(sink1), .sink_out_2(sink2),
    .sink_out_3(sink3), .sink_out_4(sink4), .sink_out_5(sink5),
    .sink_out_6(sink6), .sink_out_7(sink7)
  );

  sld_ctrl_model sld_ctrl_model_i (
    .clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull)
  );

  // ****************
  // Helpers
  // ****************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string msg);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Address byte for a given pin setting, write direction
  function automatic logic [7:0] adr(input logic [3:0] grp,
                                     input logic [2:0] p);
    return {grp, p, 1'b0};
  endfunction

  // ****************
  // Scenarios
  // ****************
  // Outputs off and the wire released after clear
  task automatic t_reset();
    chk(sinks, `SLD_OUT_OFF, "sinks after clear");
    chk({7'h00, sda_oe}, 8'h00, "data pulled after clear");
    chk({7'h00, sda_out}, 8'h00, "data driven high");
  endtask

  // Write then transfer; storage only moves on the transfer code
  task automatic t_write();
    logic ack;
    oe_n <= 1'b0;
    sld_ctrl_model_i.xfer(adr(`SLD_GROUP_ID, pins), 8'h11, 8'ha5, 1'b1, ack);
    chk({7'h00, ack}, 8'h01, "write not acked");
    chk(sinks, 8'h00, "sinks moved before transfer");
    sld_ctrl_model_i.xfer(adr(`SLD_GROUP_ID, pins), 8'h44, 8'h00, 1'b0, ack);
    sld_ctrl_model_i.hold(2);
    chk(sinks, 8'ha5, "sinks after transfer");
  endtask

  // Enable and overtemperature gating
  task automatic t_gate();
    oe_n <= 1'b1;
    sld_ctrl_model_i.hold(2);
    chk(sinks, 8'h00, "sinks with enable high");
    oe_n <= 1'b0;
    over_temp <= 1'b1;
    sld_ctrl_model_i.hold(2);
    chk(sinks, 8'h00, "sinks in overtemperature");
    over_temp <= 1'b0;
    sld_ctrl_model_i.hold(2);
    chk(sinks, 8'ha5, "sinks after gating");
  endtask

  // Read-back of the shift register
  task automatic t_read(input logic [7:0] exp);
    logic [7:0] d;
    sld_ctrl_model_i.rd(adr(`SLD_GROUP_ID, pins), d);
    chk(d, exp, "read-back data");
  endtask

  // Wrong group or pins: no ack and no shift
  task automatic t_refuse();
    logic ack;
    {pin2, pin1, pin0} <= 3'h7;
    sld_ctrl_model_i.hold(2);
    sld_ctrl_model_i.xfer(adr(4'h5, 3'h7), 8'h11, 8'h3c, 1'b1, ack);
    chk({7'h00, ack}, 8'h00, "wrong group acked");
    sld_ctrl_model_i.xfer(adr(`SLD_GROUP_ID, 3'h3), 8'h11, 8'h3c, 1'b1, ack);
    chk({7'h00, ack}, 8'h00, "wrong pins acked");
    t_read(8'ha5);
    sld_ctrl_model_i.xfer(adr(`SLD_GROUP_ID, 3'h7), 8'h11, 8'h5a, 1'b1, ack);
    sld_ctrl_model_i.xfer(adr(`SLD_GROUP_ID, 3'h7), 8'h44, 8'h00, 1'b0, ack);
    sld_ctrl_model_i.hold(2);
    chk(sinks, 8'h5a, "sinks at new pins");
  endtask

  // Clear in mid-run empties the storage and shift registers
  task automatic t_midreset();
    reset <= 1'b1;
    sld_ctrl_model_i.hold(3);
    chk(sinks, 8'h00, "sinks in clear");
    reset <= 1'b0;
    sld_ctrl_model_i.hold(3);
    t_read(`SLD_SHIFT_RESET);
  endtask

  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    t_write();
    t_gate();
    t_read(8'ha5);
    t_refuse();
    t_midreset();
    end_of_test();
  end

  // Run needs about 4300 clocks; this limit leaves ample slack
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule
